// ---- ivp_map.vh ----
`ifndef IVP_MAP_VH
`define IVP_MAP_VH
// register byte offsets
`define IVP_OFF_FLAG 8'h00
`define IVP_OFF_EN 8'h04
`define IVP_OFF_PEND 8'h08
`define IVP_OFF_VEC 8'h0C
`define IVP_OFF_PM1 8'h10
`define IVP_OFF_PM2 8'h14
`define IVP_OFF_RSTAT 8'h18
`define IVP_OFF_CCR 8'h1C
`define IVP_OFF_ISTAT 8'h20
`define IVP_OFF_IMASK 8'h24
// power_mgmt_ctrl_one bits
`define IVP_PM1_MON_EN 0
`define IVP_PM1_STOP_EN 1
`define IVP_PM1_RST_SEL 2
`define IVP_PM1_IRQ_EN 3
// power_mgmt_ctrl_two bits
`define IVP_PM2_DET_LVL 0
`define IVP_PM2_WARN_LVL 1
`define IVP_PM2_DET_FLAG 2
`define IVP_PM2_WARN_FLAG 3
// reset_status_register bits
`define IVP_RS_POR 0
`define IVP_RS_LV 1
// reset values
`define IVP_PM1_RESET 8'h01
`define IVP_CCR_RESET 8'h08
`define IVP_CCR_IBIT 3
// vector table
`define IVP_VEC_TOP 16'hFFFE
`define IVP_VEC_SWI 1
`define IVP_VEC_EXT 2
`define IVP_VEC_LVD 3
`define IVP_VEC_RTI 25
// event bits of the interrupt status register
`define IVP_EV_LVD 0
`define IVP_EV_WARN 1
`define IVP_EV_REQ 2
`endif

// ---- ivp_prio_enc.v ----
`timescale 1ns/100ps
// picks the lowest numbered pending source; registered outputs
module ivp_prio_enc #(
  parameter N = 32,
  parameter W = 5
) (
  // clock and reset
  input wire mclk_in,
  input wire nrst_in,
  input wire ce_in,
  // request vector
  input wire [N-1:0] req_in,
  // result
  output reg any_out,
  output reg [W-1:0] num_out
);
  reg [W-1:0] next_num;
  reg next_any;
  integer i;

  always @* begin
    next_num = {W{1'b0}};
    next_any = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req_in[i]) begin
        next_num = i[W-1:0];
        next_any = 1'b1;
      end
    end
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      any_out <= 1'b0;
      num_out <= {W{1'b0}};
    end else if (ce_in) begin
      any_out <= next_any;
      num_out <= next_num;
    end
  end
endmodule

// ---- ivp_top.v ----
// Summary of operation
// - vector n: high address byte at lower location, low byte at next one
// - request raised while source flag set and its local enable is 1; vector 1 (swi) needs the flag only
// - lower vector number wins; vector 0 at top is reset; n two bytes lower
// - fixed map: swi 1, pin 2, low voltage 3, rti 25, 9 10 29-31 unused
// - unused low slots never claimed by hardware sources
// - monitor runs only when enabled; select bit picks high or low trip
// - monitor off in stop modes unless stop enable set
// - monitor and stop enable both set blocks the deepest stop mode
// - power-on holds reset until above low trip, or high trip if selected; both reset flags set
// - with reset select, detection resets and holds; sets low-voltage flag
// - enabled, irq enabled, no reset select: detection sets flag, vector 3
// - warning flag set near threshold, no vector, interrupt only on irq_out via event bit 1, own level select
// - global mask bit comes out of reset set
`timescale 1ns/100ps
`include "ivp_map.vh"
module ivp_top #(
  parameter NSRC = 32
) (
  // clock, reset, enable
  input wire mclk_in,
  input wire nrst_in,
  input wire ce_in,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // peripheral flag set pulses, one per vector number
  input wire [NSRC-1:0] src_set_in,
  // analog comparator results
  input wire por_in,
  input wire below_hi_detect_in,
  input wire below_lo_detect_in,
  input wire below_hi_warn_in,
  input wire below_lo_warn_in,
  // core handshake
  input wire swi_in,
  input wire stop_req_in,
  input wire deep_stop_req_in,
  input wire vec_ack_in,
  // outputs to core and system
  output reg core_irq_out,
  output reg [15:0] vec_addr_out,
  output reg [4:0] vec_num_out,
  output reg monitor_on_out,
  output reg deep_stop_ok_out,
  output reg sys_reset_out,
  output wire irq_out
);
  ////////////////////////////////////////////////////////////////////
  // state
  reg [NSRC-1:0] src_flag;
  reg [NSRC-1:0] src_en;
  reg [7:0] power_mgmt_ctrl_one;
  reg [1:0] lvl_sel;
  reg lowvolt_detect_flag;
  reg supply_warning_flag;
  reg [1:0] reset_status_register;
  reg [7:0] condition_code_register;
  reg [2:0] istat;
  reg [2:0] imask;
  reg in_stop;
  reg hold_rst;
  wire [NSRC-1:0] pend;
  wire [NSRC-1:0] valid_src;
  wire pe_any;
  wire [4:0] pe_num;
  wire mon_en;
  wire mon_stop_en;
  wire rst_sel;
  wire lv_irq_en;
  wire mon_active;
  wire det_hit;
  wire warn_hit;
  wire lv_event;
  wire lv_reset;
  wire warn_rise;
  wire req_rise;
  reg core_irq_d;
  reg warn_d;
  genvar g;

  assign mon_en = power_mgmt_ctrl_one[`IVP_PM1_MON_EN];
  assign mon_stop_en = power_mgmt_ctrl_one[`IVP_PM1_STOP_EN];
  assign rst_sel = power_mgmt_ctrl_one[`IVP_PM1_RST_SEL];
  assign lv_irq_en = power_mgmt_ctrl_one[`IVP_PM1_IRQ_EN];

  ////////////////////////////////////////////////////////////////////
  // voltage monitor
  assign mon_active = mon_en & (~in_stop | mon_stop_en);
  assign det_hit = mon_active &
    (lvl_sel[`IVP_PM2_DET_LVL] ? below_hi_detect_in : below_lo_detect_in);
  assign warn_hit = mon_active & ~det_hit &
    (lvl_sel[`IVP_PM2_WARN_LVL] ? below_hi_warn_in : below_lo_warn_in);
  assign lv_event = det_hit & ~rst_sel & lv_irq_en;
  assign lv_reset = det_hit & rst_sel;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_go;
  wire rd_go;
  wire [7:0] wa;
  wire [31:0] wd;
  wire [3:0] ws;
  wire [31:0] wmask;
  wire wr_flag;
  wire wr_en;
  wire wr_pm1;
  wire wr_pm2;
  wire wr_ccr;
  wire wr_istat;
  wire wr_imask;
  wire wr_rstat;
  reg [31:0] next_rdata;
  reg next_rok;
  reg wr_ok;

  assign s_axi_awready = ce_in & ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ce_in & ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ce_in & ~s_axi_rvalid;
  assign wa = aw_hold ? aw_addr : s_axi_awaddr;
  assign wd = w_hold ? w_data : s_axi_wdata;
  assign ws = w_hold ? w_strb : s_axi_wstrb;
  assign wr_go = ce_in & ~s_axi_bvalid & (aw_hold | s_axi_awvalid) & (w_hold | s_axi_wvalid);
  assign rd_go = ce_in & s_axi_arvalid & ~s_axi_rvalid;
  assign wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  assign wr_flag = wr_go & (wa == `IVP_OFF_FLAG);
  assign wr_en = wr_go & (wa == `IVP_OFF_EN);
  assign wr_pm1 = wr_go & (wa == `IVP_OFF_PM1) & ws[0];
  assign wr_pm2 = wr_go & (wa == `IVP_OFF_PM2) & ws[0];
  assign wr_ccr = wr_go & (wa == `IVP_OFF_CCR) & ws[0];
  assign wr_istat = wr_go & (wa == `IVP_OFF_ISTAT) & ws[0];
  assign wr_imask = wr_go & (wa == `IVP_OFF_IMASK) & ws[0];
  assign wr_rstat = wr_go & (wa == `IVP_OFF_RSTAT) & ws[0];

  always @* begin
    case (wa)
      `IVP_OFF_FLAG, `IVP_OFF_EN, `IVP_OFF_PM1, `IVP_OFF_PM2, `IVP_OFF_CCR,
      `IVP_OFF_ISTAT, `IVP_OFF_IMASK, `IVP_OFF_RSTAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @* begin
    next_rok = 1'b1;
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      `IVP_OFF_FLAG: next_rdata = src_flag;
      `IVP_OFF_EN: next_rdata = src_en;
      `IVP_OFF_PEND: next_rdata = pend;
      `IVP_OFF_VEC: next_rdata = {7'd0, pe_any, 3'd0, vec_num_out, vec_addr_out};
      `IVP_OFF_PM1: next_rdata = {24'd0, power_mgmt_ctrl_one};
      `IVP_OFF_PM2: next_rdata = {28'd0, supply_warning_flag, lowvolt_detect_flag, lvl_sel};
      `IVP_OFF_RSTAT: next_rdata = {30'd0, reset_status_register};
      `IVP_OFF_CCR: next_rdata = {24'd0, condition_code_register};
      `IVP_OFF_ISTAT: next_rdata = {29'd0, istat};
      `IVP_OFF_IMASK: next_rdata = {29'd0, imask};
      default: next_rok = 1'b0;
    endcase
  end

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end else if (ce_in) begin
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_hold <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_hold <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // source flags and enables
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_src
      if (g == 0 || g == 9 || g == 10 || g >= 29) begin : g_none
        assign valid_src[g] = 1'b0;
      end else begin : g_used
        assign valid_src[g] = 1'b1;
      end
    end
  endgenerate

  // vector 1 has no enable; vector 3 enable follows the monitor irq enable
  assign pend = src_flag & valid_src &
    (src_en | ({{(NSRC-2){1'b0}}, 2'b10}));

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      src_flag <= {NSRC{1'b0}};
      src_en <= {NSRC{1'b0}};
    end else if (ce_in) begin
      // set wins over a write-one clear in the same cycle
      src_flag <= ((src_flag & ~(wr_flag ? wd[NSRC-1:0] & wmask[NSRC-1:0] : {NSRC{1'b0}}))
        | src_set_in | ({{(NSRC-2){1'b0}}, swi_in, 1'b0})
        | ({{(NSRC-4){1'b0}}, lv_event, 3'b000})) & valid_src;
      if (wr_en) begin
        src_en <= ((src_en & ~wmask[NSRC-1:0]) | (wd[NSRC-1:0] & wmask[NSRC-1:0])) & valid_src;
      end else if (wr_pm1) begin
        src_en[`IVP_VEC_LVD] <= wd[`IVP_PM1_IRQ_EN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // priority and vector address
  ivp_prio_enc #(
    .N(NSRC),
    .W(5)
  ) u_prio (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .req_in(pend),
    .any_out(pe_any),
    .num_out(pe_num)
  );

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      condition_code_register <= `IVP_CCR_RESET;
      vec_num_out <= 5'd0;
      vec_addr_out <= `IVP_VEC_TOP;
      core_irq_out <= 1'b0;
    end else if (ce_in) begin
      vec_num_out <= pe_num;
      // address of the high byte; the low byte sits at the next address
      vec_addr_out <= `IVP_VEC_TOP - {10'd0, pe_num, 1'b0};
      core_irq_out <= pe_any & ~condition_code_register[`IVP_CCR_IBIT];
      if (vec_ack_in) begin
        condition_code_register[`IVP_CCR_IBIT] <= 1'b1;
      end else if (wr_ccr) begin
        condition_code_register <= wd[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power management and reset status
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      power_mgmt_ctrl_one <= `IVP_PM1_RESET;
      lvl_sel <= 2'b00;
      lowvolt_detect_flag <= 1'b0;
      supply_warning_flag <= 1'b0;
      in_stop <= 1'b0;
      monitor_on_out <= 1'b0;
      deep_stop_ok_out <= 1'b0;
    end else if (ce_in) begin
      if (wr_pm1) begin
        power_mgmt_ctrl_one <= wd[7:0];
      end else if (wr_en & ws[0]) begin
        power_mgmt_ctrl_one[`IVP_PM1_IRQ_EN] <= wd[`IVP_VEC_LVD];
      end
      if (wr_pm2) begin
        lvl_sel <= wd[1:0];
      end
      lowvolt_detect_flag <= lv_event |
        (lowvolt_detect_flag & ~(wr_pm2 & wd[`IVP_PM2_DET_FLAG]));
      supply_warning_flag <= warn_hit |
        (supply_warning_flag & ~(wr_pm2 & wd[`IVP_PM2_WARN_FLAG]));
      in_stop <= stop_req_in | deep_stop_req_in;
      monitor_on_out <= mon_active;
      deep_stop_ok_out <= deep_stop_req_in & ~(mon_en & mon_stop_en);
    end
  end

  // reset hold and reset status; the power-on path runs regardless of enable
  always @(posedge mclk_in) begin
    if (por_in) begin
      reset_status_register <= 2'b11;
      hold_rst <= 1'b1;
    end else if (hold_rst) begin
      hold_rst <= below_lo_detect_in | (lvl_sel[`IVP_PM2_DET_LVL] & below_hi_detect_in);
    end else if (ce_in & lv_reset) begin
      reset_status_register <= 2'b10;
      hold_rst <= 1'b1;
    end else if (ce_in & wr_rstat) begin
      reset_status_register <= reset_status_register & ~wd[1:0];
    end
  end

  always @(posedge mclk_in) begin
    if (por_in) begin
      sys_reset_out <= 1'b1;
    end else begin
      sys_reset_out <= hold_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      istat <= 3'b000;
      imask <= 3'b000;
      core_irq_d <= 1'b0;
      warn_d <= 1'b0;
    end else if (ce_in) begin
      core_irq_d <= core_irq_out;
      warn_d <= supply_warning_flag;
      istat <= (istat & ~(wr_istat ? wd[2:0] : 3'b000)) |
        {req_rise, warn_rise, lv_event};
      if (wr_imask) begin
        imask <= wd[2:0];
      end
    end
  end

  assign warn_rise = supply_warning_flag & ~warn_d;
  assign req_rise = core_irq_out & ~core_irq_d;
  assign irq_out = |(istat & imask);
endmodule

// ---- ivp_checker.sv ----
`timescale 1ns/100ps
module ivp_checker (
  // clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_rresp,
  // core and supply
  input wire vec_ack_in,
  input wire por_in,
  input wire below_lo_detect_in,
  input wire core_irq_out,
  input wire [4:0] vec_num_out,
  input wire [15:0] vec_addr_out,
  input wire sys_reset_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire wr_hs = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire rd_hs = s_axi_arvalid & s_axi_arready;
  reg [5:0] cause_hist;
  // recent writes or acks that may legally withdraw the request
  always @(posedge mclk_in) begin
    if (!nrst_in)
      cause_hist <= 6'h00;
    else
      cause_hist <= {cause_hist[4:0], s_axi_bvalid | vec_ack_in};
  end
  ////////////////////////////////////////////////////////////////////
  property p_vec_addr;
    vec_addr_out == 16'hFFFE - {10'h000, vec_num_out, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address off its number");
  property p_unused;
    core_irq_out |-> !(vec_num_out inside {5'h00, 5'h09, 5'h0A, 5'h1D, 5'h1E, 5'h1F});
  endproperty
  a_unused: assert property (p_unused) else $error("unused slot claimed");
  property p_ack_mask;
    vec_ack_in |-> ##[1:3] !core_irq_out;
  endproperty
  a_ack_mask: assert property (p_ack_mask) else $error("mask not set by vector fetch");
  property p_req_hold;
    $fell(core_irq_out) |-> (cause_hist != 6'h00);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped on its own");
  property p_wr_ans;
    wr_hs |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_unmapped;
    rd_hs && (s_axi_araddr > 8'h24) |=> s_axi_rvalid && (s_axi_rresp == 2'b10);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_por;
    por_in |-> ##[1:2] sys_reset_out;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset not held");
  property p_lv_hold;
    sys_reset_out && below_lo_detect_in |=> sys_reset_out;
  endproperty
  a_lv_hold: assert property (p_lv_hold) else $error("reset released below trip");
  c_write: cover property (wr_hs);
  c_lvd_vec: cover property (core_irq_out && vec_num_out == 5'h03);
  c_rst_end: cover property ($fell(sys_reset_out));
endmodule
bind ivp_top ivp_checker u_chk (.mclk_in, .nrst_in, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .vec_ack_in, .por_in,
  .below_lo_detect_in, .core_irq_out, .vec_num_out, .vec_addr_out, .sys_reset_out);

// ---- ivp_core_model.sv ----
`timescale 1ns/100ps
module ivp_core_model (
  // clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // request side
  input wire slow_in,
  input wire core_irq_in,
  input wire [4:0] vec_num_in,
  input wire [15:0] vec_addr_in,
  // fetch results
  output reg vec_ack_out,
  output reg [4:0] got_num_out,
  output reg [15:0] got_addr_out,
  output reg [7:0] got_cnt_out
);
  reg [3:0] step;
  always @(posedge mclk_in) begin
    vec_ack_out <= 1'b0;
    if (!nrst_in) begin
      step <= 4'h0;
      got_cnt_out <= 8'h00;
    end else if (step != 4'h0) begin
      step <= step - 4'h1;
      // fetch after stacking; the ack sets the mask bit
      if (step == 4'h4) begin
        vec_ack_out <= 1'b1;
        got_num_out <= vec_num_in;
        got_addr_out <= vec_addr_in;
        got_cnt_out <= got_cnt_out + 8'h01;
      end
    end else if (core_irq_in) begin
      // finish instruction, stack pc low, pc high, index, acc, ccr
      step <= slow_in ? 4'hE : 4'hA;
    end
  end
endmodule

// ---- irq_vector_priority_lvd_tb_top.sv ----
`timescale 1ns/100ps
module irq_vector_priority_lvd_tb_top;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [31:0] w_d = 32'h0000_0000, src = 32'h0000_0000, rv;
  logic por = 1, bhd = 0, bld = 0, bhw = 0, blw = 0, software_interrupt = 0, stp = 0, dstp = 0, slow = 0;
  logic ce = 1;
  logic [1:0] rr, br;
  wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, ack, irq, cirq, mon, dsok, srst;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_d;
  wire [15:0] va, ga;
  wire [4:0] vn, gn;
  wire [7:0] gc;
  int fail_count = 0;
  int checks_done = 0;
  always #12.5 mclk_in = ~mclk_in;
  ivp_top dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .src_set_in(src), .por_in(por), .below_hi_detect_in(bhd), .below_lo_detect_in(bld),
    .below_hi_warn_in(bhw), .below_lo_warn_in(blw), .swi_in(software_interrupt), .stop_req_in(stp),
    .deep_stop_req_in(dstp), .vec_ack_in(ack), .core_irq_out(cirq), .vec_addr_out(va),
    .vec_num_out(vn), .monitor_on_out(mon), .deep_stop_ok_out(dsok),
    .sys_reset_out(srst), .irq_out(irq));
  ivp_core_model core (.mclk_in(mclk_in), .nrst_in(nrst_in), .slow_in(slow),
    .core_irq_in(cirq), .vec_num_in(vn), .vec_addr_in(va), .vec_ack_out(ack),
    .got_num_out(gn), .got_addr_out(ga), .got_cnt_out(gc));
  ////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    @(posedge mclk_in);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1;
    w_v <= 1;
    b_r <= 1;
    for (n = 0; n < 30; n++) begin
      @(negedge mclk_in);
      ha = aw_rdy;
      hw = w_rdy;
      hb = b_v;
      br = b_resp;
      @(posedge mclk_in);
      if (ha) aw_v <= 0;
      if (hw) w_v <= 0;
      if (hb) break;
    end
    b_r <= 0;
    if (n == 30) chk("write wait", 0, 1);
  endtask
  task rd(input logic [7:0] a);
    int n;
    logic ha, hr;
    @(posedge mclk_in);
    ar_a <= a;
    ar_v <= 1;
    r_r <= 1;
    for (n = 0; n < 30; n++) begin
      @(negedge mclk_in);
      ha = ar_rdy;
      hr = r_v;
      rv = r_d;
      rr = r_resp;
      @(posedge mclk_in);
      if (ha) ar_v <= 0;
      if (hr) break;
    end
    r_r <= 0;
    if (n == 30) chk("read wait", 0, 1);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, rv);
  endtask
  task lvl(input int c, input string n, input logic e, input logic g);
    chk(n, 32'(e), 32'(g));
  endtask
  task take(input logic [4:0] en, input logic [15:0] ea);
    logic [7:0] c0;
    int n;
    c0 = gc;
    wr(8'h1C, 32'h0000_0000);
    for (n = 0; n < 60 && gc == c0; n++) @(negedge mclk_in);
    chk("vector number", 32'(en), 32'(gn));
    chk("vector address", 32'(ea), 32'(ga));
    chk("fetch count", 32'(c0 + 8'h01), 32'(gc));
    rc(8'h1C, 32'h0000_0008, "mask after fetch");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk_in);
    nrst_in <= 1'b1;
    por <= 1'b0;
    rc(8'h1C, 32'h0000_0008, "ccr reset");
    rc(8'h18, 32'h0000_0003, "por status at start");
    rc(8'h10, 32'h0000_0001, "pm1 reset");
    rd(8'h28);
    chk("unmapped resp", 32'h0000_0002, 32'(rr));
    wr(8'h28, 32'h0000_0000);
    chk("unmapped write resp", 32'h0000_0002, 32'(br));
    lvl(0, "irq idle", 0, cirq);
    $display("test reset done");
    wr(8'h04, 32'hFFFF_FFFF);
    chk("write resp", 32'h0000_0000, 32'(br));
    src <= 32'hE200_0605;
    @(posedge mclk_in);
    src <= 32'h0000_0000;
    rc(8'h08, 32'h0200_0004, "pending");
    take(5'h02, 16'hFFFA);
    wr(8'h00, 32'h0000_0004);
    take(5'h19, 16'hFFCC);
    wr(8'h04, 32'h0000_0000);
    rc(8'h08, 32'h0000_0000, "pending off");
    rc(8'h00, 32'h0200_0000, "flag kept");
    wr(8'h04, 32'h0200_0000);
    rc(8'h08, 32'h0200_0000, "pending again");
    wr(8'h00, 32'h0200_0000);
    wr(8'h04, 32'h0000_0000);
    $display("test priority done");
    slow <= 1;
    software_interrupt <= 1;
    @(posedge mclk_in);
    software_interrupt <= 0;
    take(5'h01, 16'hFFFC);
    slow <= 0;
    wr(8'h00, 32'h0000_0002);
    ce <= 1'b0;
    software_interrupt <= 1;
    @(posedge mclk_in);
    software_interrupt <= 0;
    ce <= 1'b1;
    rc(8'h00, 32'h0000_0000, "frozen by enable");
    $display("test software done");
    wr(8'h14, 32'h0000_0002);
    wr(8'h10, 32'h0000_0009);
    @(negedge mclk_in);
    lvl(0, "monitor on", 1, mon);
    @(posedge mclk_in);
    bhw <= 1;
    rc(8'h14, 32'h0000_000A, "warning");
    rc(8'h08, 32'h0000_0000, "warning no req");
    {bld, bhd, blw} <= 3'b111;
    rc(8'h14, 32'h0000_000E, "detect");
    wr(8'h24, 32'h0000_0001);
    @(negedge mclk_in);
    lvl(0, "irq raised", 1, irq);
    wr(8'h24, 32'h0000_0000);
    @(negedge mclk_in);
    lvl(0, "irq masked", 0, irq);
    wr(8'h24, 32'h0000_0001);
    take(5'h03, 16'hFFF8);
    {bld, bhd, blw, bhw} <= 4'h0;
    wr(8'h14, 32'h0000_000E);
    wr(8'h00, 32'h0000_0008);
    rc(8'h20, 32'h0000_0007, "event status");
    wr(8'h20, 32'h0000_0007);
    @(negedge mclk_in);
    lvl(0, "irq cleared", 0, irq);
    $display("test low voltage done");
    wr(8'h10, 32'h0000_0003);
    stp <= 1;
    dstp <= 1;
    repeat (3) @(negedge mclk_in);
    lvl(0, "monitor in stop", 1, mon);
    lvl(0, "deep stop refused", 0, dsok);
    wr(8'h10, 32'h0000_0001);
    repeat (3) @(negedge mclk_in);
    lvl(0, "monitor off in stop", 0, mon);
    lvl(0, "deep stop allowed", 1, dsok);
    @(posedge mclk_in);
    stp <= 0;
    dstp <= 0;
    $display("test stop done");
    wr(8'h10, 32'h0000_0005);
    wr(8'h14, 32'h0000_0001);
    bhd <= 1;
    repeat (3) @(negedge mclk_in);
    lvl(0, "lv reset", 1, srst);
    rc(8'h18, 32'h0000_0002, "lv status");
    bhd <= 0;
    repeat (3) @(negedge mclk_in);
    lvl(0, "lv release", 0, srst);
    wr(8'h18, 32'h0000_0003);
    por <= 1;
    {bld, bhd} <= 2'b11;
    @(posedge mclk_in);
    por <= 0;
    repeat (4) @(negedge mclk_in);
    lvl(0, "por hold", 1, srst);
    @(posedge mclk_in);
    {bld, bhd} <= 2'b00;
    repeat (3) @(negedge mclk_in);
    lvl(0, "por release", 0, srst);
    rc(8'h18, 32'h0000_0003, "por status");
    $display("test reset sources done");
    report_and_stop;
  end
endmodule
